//--- testbench/irts_partner.sv
`timescale 1ns/1ps
`default_nettype none
// =====================================
// cpu sequencer and transfer controller stand-in
module irts_partner (
    // clock and reset
    input wire logic clk_sys,
    input wire logic sys_rst,
    // transfer link
    input wire irts_pkg::irts_req_t xfer_req,
    input wire logic last_sel,
    output logic xfer_done,
    output logic xfer_last,
    // cpu link
    output logic cpu_insn_end
);
    logic [1:0] insn_cnt;
    logic [1:0] xfer_cnt;
    // one instruction ends every fourth state
    always_ff @(posedge clk_sys or posedge sys_rst) begin
        if (sys_rst) begin
            insn_cnt <= 2'h0;
        end else begin
            insn_cnt <= insn_cnt + 2'h1;
        end
    end
    assign cpu_insn_end = (insn_cnt == 2'h3);
    // completion comes three states after the request, never two in a row
    always_ff @(posedge clk_sys or posedge sys_rst) begin
        if (sys_rst) begin
            xfer_cnt <= 2'h0;
            xfer_done <= 1'b0;
        end else if (xfer_done) begin
            xfer_cnt <= 2'h0;
            xfer_done <= 1'b0;
        end else if (xfer_req.req) begin
            xfer_cnt <= xfer_cnt + 2'h1;
            xfer_done <= (xfer_cnt == 2'h2);
        end
    end
    // the count flag only means something beside a completion
    assign xfer_last = xfer_done ? last_sel : ~last_sel;
endmodule : irts_partner
`default_nettype wire

//--- testbench/irts_top_test.sv
`timescale 1ns/1ps
`default_nettype none
module irts_top_test;
    logic clk_sys = 1'b0;
    logic sys_rst = 1'b1;
    logic [7:0] paddr = 8'h00;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [31:0] pwdata = 32'h0;
    logic [7:0] src_event = 8'h00;
    logic last_sel = 1'b0;
    logic [31:0] prdata, rd;
    logic pready, pslverr, handler_start, cpu_insn_end, xfer_done, xfer_last, err;
    logic [2:0] seen;
    irts_pkg::irts_req_t cpu_irq, xfer_req;
    int miscompares = 0;
    int comparisons = 0;
    initial forever #5 clk_sys = ~clk_sys;
    irts_top i_irts_top (.clk_sys(clk_sys), .sys_rst(sys_rst), .paddr(paddr), .psel(psel), .penable(penable),
        .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .src_event(src_event), .cpu_insn_end(cpu_insn_end), .cpu_irq(cpu_irq), .handler_start(handler_start),
        .xfer_req(xfer_req), .xfer_done(xfer_done), .xfer_last(xfer_last));
    irts_partner i_irts_partner (.clk_sys(clk_sys), .sys_rst(sys_rst), .xfer_req(xfer_req), .last_sel(last_sel),
        .xfer_done(xfer_done), .xfer_last(xfer_last), .cpu_insn_end(cpu_insn_end));
    // =====================================
    // checking and closing
    task automatic report_and_stop;
        $display("miscompares=%0d comparisons=%0d", miscompares, comparisons);
        if (miscompares == 0 && comparisons > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask : report_and_stop
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        comparisons++;
        if (got !== exp) begin
            miscompares++;
            $display("[ERR] %0t got %h expected %h", $time, got, exp);
        end
    endtask : chk
    task automatic give_up;
        miscompares++;
        $display("[ERR] %0t wait ran out", $time);
        report_and_stop();
    endtask : give_up
    // =====================================
    // access tasks
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge clk_sys);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk_sys);
        penable <= 1'b1;
        do begin
            @(posedge clk_sys);
            n++;
            if (n > 20) give_up();
        end while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb
    task automatic pulse(input logic [7:0] v);
        @(posedge clk_sys);
        src_event <= v;
        @(posedge clk_sys);
        src_event <= 8'h00;
    endtask : pulse
    // kind 0: until handler start, kind 1: until a transfer completes
    task automatic wait_for(input int kind);
        int n;
        for (n = 0; n < 200; n++) begin
            @(posedge clk_sys);
            if (kind == 0 && cpu_irq.req === 1'b1) seen = cpu_irq.src;
            if (kind == 1 && xfer_req.req === 1'b1) seen = xfer_req.src;
            if (kind == 0 && handler_start === 1'b1) break;
            if (kind == 1 && xfer_req.req === 1'b1 && xfer_done === 1'b1) break;
        end
        if (n == 200) give_up();
    endtask : wait_for
    // =====================================
    // main sequence
    initial begin
        repeat (12) @(posedge clk_sys);
        sys_rst <= 1'b0;
        apb(1'b0, irts_pkg::OFS_MASK, 32'h0);
        chk(rd, 32'h3);
        apb(1'b0, 8'h20, 32'h0);
        chk({31'h0, err}, 32'h1);
        apb(1'b1, irts_pkg::OFS_ENABLE, 32'h70);
        pulse(8'h10);
        repeat (10) @(posedge clk_sys);
        chk({31'h0, cpu_irq.req}, 32'h0);
        apb(1'b0, irts_pkg::OFS_FLAG, 32'h0);
        chk(rd, 32'h10);
        apb(1'b1, irts_pkg::OFS_MASK, 32'h0);
        wait_for(0);
        chk({29'h0, seen}, 32'h4);
        apb(1'b0, irts_pkg::OFS_STATUS, 32'h0);
        chk({31'h0, rd[15:8] >= 8'h0B && rd[15:8] <= 8'h20}, 32'h1);
        apb(1'b0, irts_pkg::OFS_MASK, 32'h0);
        chk(rd, 32'h3);
        // masked source: the clear lands at once
        apb(1'b1, irts_pkg::OFS_FLAG, 32'h0);
        apb(1'b0, irts_pkg::OFS_FLAG, 32'h0);
        chk(rd, 32'h0);
        apb(1'b1, irts_pkg::OFS_ACT_EN, 32'h60);
        apb(1'b1, irts_pkg::OFS_IRQ_SEL, 32'h40);
        pulse(8'h60);
        wait_for(1);
        chk({29'h0, seen}, 32'h5);
        wait_for(1);
        chk({29'h0, seen}, 32'h6);
        repeat (3) @(posedge clk_sys);
        apb(1'b0, irts_pkg::OFS_FLAG, 32'h0);
        chk(rd, 32'h40);
        apb(1'b0, irts_pkg::OFS_ACT_EN, 32'h0);
        chk(rd, 32'h20);
        last_sel <= 1'b1;
        pulse(8'h20);
        wait_for(1);
        repeat (3) @(posedge clk_sys);
        apb(1'b0, irts_pkg::OFS_ACT_EN, 32'h0);
        chk(rd, 32'h0);
        // both sources now reach the cpu; the lower index goes first
        apb(1'b1, irts_pkg::OFS_MASK, 32'h0);
        wait_for(0);
        chk({29'h0, seen}, 32'h5);
        // external level-1 source, 16-bit two-state stack: 3+1+1+4+2+1+2 states
        apb(1'b1, irts_pkg::OFS_LEVEL, 32'h0000_0001);
        apb(1'b1, irts_pkg::OFS_ENABLE, 32'h0000_0071);
        apb(1'b1, irts_pkg::OFS_BUSCFG, 32'h0000_0020);
        pulse(8'h01);
        apb(1'b1, irts_pkg::OFS_MASK, 32'h0000_0001);
        wait_for(0);
        chk({29'h0, seen}, 32'h0);
        apb(1'b0, irts_pkg::OFS_STATUS, 32'h0);
        chk({24'h0, rd[15:8]}, 32'h0000_000E);
        apb(1'b0, irts_pkg::OFS_FLAG, 32'h0);
        chk(rd, 32'h0000_0061);
        report_and_stop();
    end
endmodule : irts_top_test
`default_nettype wire

//--- verilog/irts_pkg.sv
package irts_pkg;
    localparam int NSRC = 8;
    // sources 0..3 come from pins, the rest from on-chip peripherals
    localparam logic [7:0] EXT_SRC_MASK = 8'h0F;
    localparam logic [3:0] PRIO_EXT_ST = 4'h3;
    localparam logic [3:0] PRIO_INT_ST = 4'h2;
    localparam logic [1:0] MASK_DELAY_ST = 2'h2;
    localparam logic [1:0] BLOCK_INSNS = 2'h2;
    localparam logic [7:0] RESP_MIN_ST = 8'h0B;
    // per-access state costs
    localparam logic [5:0] ACC_INT_ST = 6'h01;
    localparam logic [5:0] ACC_E8_2_ST = 6'h04;
    localparam logic [5:0] ACC_E8_3_ST = 6'h06;
    localparam logic [5:0] ACC_E16_2_ST = 6'h02;
    localparam logic [5:0] ACC_E16_3_ST = 6'h03;
    localparam logic [1:0] BUS_INT = 2'h0;
    localparam logic [1:0] BUS_E8 = 2'h1;
    localparam logic [1:0] BUS_E16 = 2'h2;
    // register byte offsets
    localparam logic [7:0] OFS_FLAG = 8'h00;
    localparam logic [7:0] OFS_ENABLE = 8'h04;
    localparam logic [7:0] OFS_ACT_EN = 8'h08;
    localparam logic [7:0] OFS_IRQ_SEL = 8'h0C;
    localparam logic [7:0] OFS_LEVEL = 8'h10;
    localparam logic [7:0] OFS_MASK = 8'h14;
    localparam logic [7:0] OFS_BUSCFG = 8'h18;
    localparam logic [7:0] OFS_STATUS = 8'h1C;
    localparam logic [1:0] MASK_RST = 2'h3;

    typedef struct packed {
        logic [1:0] bus;
        logic three;
        logic [2:0] waits;
    } irts_acc_t;

    typedef struct packed {
        logic req;
        logic [2:0] src;
    } irts_req_t;

    typedef enum logic [2:0] {
        SEQ_IDLE, SEQ_PRIO, SEQ_WAIT, SEQ_INT1, SEQ_SAVE, SEQ_VEC, SEQ_INT2, SEQ_FETCH
    } irts_state_t;

    function automatic logic [5:0] acc_states(irts_acc_t a);
        logic [5:0] s;
        s = ACC_INT_ST;
        if (a.bus == BUS_E8) begin
            s = a.three ? 6'(ACC_E8_3_ST + {2'h0, a.waits, 1'b0}) : ACC_E8_2_ST;
        end else if (a.bus == BUS_E16) begin
            s = a.three ? 6'(ACC_E16_3_ST + {3'h0, a.waits}) : ACC_E16_2_ST;
        end
        return s;
    endfunction : acc_states
endpackage : irts_pkg

//--- verilog/irts_prio_enc.sv
`timescale 1ns/1ps
`default_nettype none
// =====================================
// fixed default priority: lowest index wins
module irts_prio_enc (
    // requests
    input wire logic [irts_pkg::NSRC-1:0] req,
    // winner
    output logic any,
    output logic [2:0] idx
);
    always_comb begin
        any = 1'b0;
        idx = 3'h0;
        for (int i = irts_pkg::NSRC - 1; i >= 0; i--) begin
            if (req[i]) begin
                any = 1'b1;
                idx = 3'(i);
            end
        end
    end
endmodule : irts_prio_enc
`default_nettype wire

//--- verilog/irts_top.sv
`timescale 1ns/1ps
`default_nettype none
module irts_top (
    // clock and reset
    input wire logic clk_sys,
    input wire logic sys_rst,
    // apb slave
    input wire logic [7:0] paddr,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // interrupt sources
    input wire logic [7:0] src_event,
    // cpu exception sequencer
    input wire logic cpu_insn_end,
    output irts_pkg::irts_req_t cpu_irq,
    output logic handler_start,
    // data transfer controller
    output irts_pkg::irts_req_t xfer_req,
    input wire logic xfer_done,
    input wire logic xfer_last
);
    // =====================================
    // state
    logic [7:0] flag_reg, en_reg, act_reg, sel_reg, lvl_reg;
    logic [7:0] flag_clr_reg, en_clr_reg;
    logic [1:0] mask_reg, mask_stage_reg, mask_dly_reg, blk_reg;
    logic mask_wait_reg;
    irts_pkg::irts_acc_t stk_cfg_reg, prg_cfg_reg;
    irts_pkg::irts_state_t state_reg;
    logic [5:0] cnt_reg;
    logic [7:0] resp_reg, resp_last_reg;
    logic ext_reg, end_seen_reg;
    irts_pkg::irts_req_t cpu_irq_reg, xfer_req_reg;
    logic handler_start_reg;
    logic [31:0] prdata_reg;
    logic pready_reg, pslverr_reg;

    assign prdata = prdata_reg;
    assign pready = pready_reg;
    assign pslverr = pslverr_reg;
    assign cpu_irq = cpu_irq_reg;
    assign xfer_req = xfer_req_reg;
    assign handler_start = handler_start_reg;

    // =====================================
    // per-source steering
    logic [7:0] lvl_ok, cpu_cand, dtc_cand;
    logic mask_i, mask_ui;
    assign mask_i = mask_reg[0];
    assign mask_ui = mask_reg[1];

    for (genvar g = 0; g < irts_pkg::NSRC; g++) begin : g_src
        assign lvl_ok[g] = lvl_reg[g] ? (!mask_i || !mask_ui) : !mask_i;
        assign cpu_cand[g] = flag_reg[g] & en_reg[g] & ~act_reg[g] & lvl_ok[g];
        assign dtc_cand[g] = flag_reg[g] & en_reg[g] & act_reg[g];
    end

    logic cpu_any, dtc_any;
    logic [2:0] cpu_idx, dtc_idx;

    irts_prio_enc u_cpu_enc (
        .req(cpu_cand),
        .any(cpu_any),
        .idx(cpu_idx)
    );

    irts_prio_enc u_dtc_enc (
        .req(dtc_cand),
        .any(dtc_any),
        .idx(dtc_idx)
    );

    // =====================================
    // apb decode
    logic acc, wr;
    logic wr_flag, wr_en, wr_act, wr_sel, wr_lvl, wr_mask, wr_cfg;
    assign acc = psel & penable & pready_reg;
    assign wr = acc & pwrite;
    assign wr_flag = wr && paddr == irts_pkg::OFS_FLAG;
    assign wr_en = wr && paddr == irts_pkg::OFS_ENABLE;
    assign wr_act = wr && paddr == irts_pkg::OFS_ACT_EN;
    assign wr_sel = wr && paddr == irts_pkg::OFS_IRQ_SEL;
    assign wr_lvl = wr && paddr == irts_pkg::OFS_LEVEL;
    assign wr_mask = wr && paddr == irts_pkg::OFS_MASK;
    assign wr_cfg = wr && paddr == irts_pkg::OFS_BUSCFG;

    logic [31:0] rd_data;
    logic rd_hit;
    always_comb begin
        rd_data = 32'h0000_0000;
        rd_hit = 1'b1;
        if (paddr == irts_pkg::OFS_FLAG) begin
            rd_data[7:0] = flag_reg;
        end else if (paddr == irts_pkg::OFS_ENABLE) begin
            rd_data[7:0] = en_reg;
        end else if (paddr == irts_pkg::OFS_ACT_EN) begin
            rd_data[7:0] = act_reg;
        end else if (paddr == irts_pkg::OFS_IRQ_SEL) begin
            rd_data[7:0] = sel_reg;
        end else if (paddr == irts_pkg::OFS_LEVEL) begin
            rd_data[7:0] = lvl_reg;
        end else if (paddr == irts_pkg::OFS_MASK) begin
            rd_data[1:0] = mask_reg;
        end else if (paddr == irts_pkg::OFS_BUSCFG) begin
            rd_data[5:0] = stk_cfg_reg;
            rd_data[13:8] = prg_cfg_reg;
        end else if (paddr == irts_pkg::OFS_STATUS) begin
            rd_data[2:0] = cpu_irq_reg.src;
            rd_data[3] = cpu_irq_reg.req;
            rd_data[4] = xfer_req_reg.req;
            rd_data[5] = blk_reg != 2'h0;
            rd_data[15:8] = resp_last_reg;
        end else begin
            rd_hit = 1'b0;
        end
    end

    // zero-wait slave: answer is registered in the setup cycle
    always_ff @(posedge clk_sys or posedge sys_rst) begin
        if (sys_rst) begin
            pready_reg <= 1'b0;
            pslverr_reg <= 1'b0;
            prdata_reg <= 32'h0000_0000;
        end else begin
            pready_reg <= psel & ~penable;
            pslverr_reg <= psel & ~penable & ~rd_hit;
            prdata_reg <= (psel & ~penable & ~pwrite) ? rd_data : 32'h0000_0000;
        end
    end

    // =====================================
    // transfer controller request
    logic xs_done, xs_sel;
    logic [2:0] xs;
    assign xs = xfer_req_reg.src;
    assign xs_done = xfer_req_reg.req & xfer_done;
    assign xs_sel = sel_reg[xs];

    always_ff @(posedge clk_sys or posedge sys_rst) begin
        if (sys_rst) begin
            xfer_req_reg <= '0;
        end else if (xs_done) begin
            xfer_req_reg.req <= 1'b0;
        end else if (!xfer_req_reg.req && dtc_any) begin
            xfer_req_reg <= '{req: 1'b1, src: dtc_idx};
        end
    end

    // =====================================
    // source flags, enables and steering bits
    logic [7:0] xs_onehot, flag_clr_now, stage_f, stage_e, en_clr_now;
    assign xs_onehot = 8'h01 << xs;
    // unmasked clears wait for the instruction boundary, masked ones act now
    assign stage_f = wr_flag ? (~pwdata[7:0] & lvl_ok) : 8'h00;
    assign stage_e = wr_en ? (~pwdata[7:0] & en_reg & lvl_ok) : 8'h00;
    assign en_clr_now = cpu_insn_end ? en_clr_reg : 8'h00;
    assign flag_clr_now = (wr_flag ? (~pwdata[7:0] & ~lvl_ok) : 8'h00)
                        | (cpu_insn_end ? flag_clr_reg : 8'h00)
                        | ((xs_done && !xs_sel && !xfer_last) ? xs_onehot : 8'h00);

    always_ff @(posedge clk_sys or posedge sys_rst) begin
        if (sys_rst) begin
            flag_reg <= 8'h00;
            flag_clr_reg <= 8'h00;
        end else begin
            // a new event beats any clear in the same cycle
            flag_reg <= (flag_reg & ~flag_clr_now) | src_event;
            flag_clr_reg <= (cpu_insn_end ? 8'h00 : flag_clr_reg) | stage_f;
        end
    end

    always_ff @(posedge clk_sys or posedge sys_rst) begin
        if (sys_rst) begin
            en_reg <= 8'h00;
            en_clr_reg <= 8'h00;
        end else begin
            if (wr_en) begin
                en_reg <= (pwdata[7:0] | (en_reg & lvl_ok)) & ~en_clr_now;
            end else begin
                en_reg <= en_reg & ~en_clr_now;
            end
            en_clr_reg <= ((cpu_insn_end ? 8'h00 : en_clr_reg) & ~(wr_en ? pwdata[7:0] : 8'h00)) | stage_e;
        end
    end

    always_ff @(posedge clk_sys or posedge sys_rst) begin
        if (sys_rst) begin
            act_reg <= 8'h00;
            sel_reg <= 8'h00;
            lvl_reg <= 8'h00;
            stk_cfg_reg <= '0;
            prg_cfg_reg <= '0;
        end else begin
            if (wr_act) begin
                act_reg <= pwdata[7:0];
            end else if (xs_done && (xs_sel || xfer_last)) begin
                act_reg <= act_reg & ~xs_onehot;
            end
            if (wr_sel) begin
                sel_reg <= pwdata[7:0];
            end
            if (wr_lvl) begin
                lvl_reg <= pwdata[7:0];
            end
            if (wr_cfg) begin
                stk_cfg_reg <= pwdata[5:0];
                prg_cfg_reg <= pwdata[13:8];
            end
        end
    end

    // =====================================
    // mask bits and control-instruction blocking
    logic seq_masks;
    assign seq_masks = state_reg == irts_pkg::SEQ_SAVE && cnt_reg == 6'h00;

    always_ff @(posedge clk_sys or posedge sys_rst) begin
        if (sys_rst) begin
            mask_reg <= irts_pkg::MASK_RST;
            mask_stage_reg <= irts_pkg::MASK_RST;
            mask_wait_reg <= 1'b0;
            mask_dly_reg <= 2'h0;
        end else begin
            if (wr_mask) begin
                mask_stage_reg <= pwdata[1:0];
                mask_wait_reg <= 1'b1;
            end else if (cpu_insn_end && mask_wait_reg) begin
                mask_wait_reg <= 1'b0;
            end
            // the countdown runs on its own so a new write cannot freeze it at one
            if (cpu_insn_end && mask_wait_reg && !wr_mask) begin
                mask_dly_reg <= irts_pkg::MASK_DELAY_ST;
            end else if (mask_dly_reg != 2'h0) begin
                mask_dly_reg <= mask_dly_reg - 2'h1;
            end
            if (seq_masks) begin
                mask_reg <= 2'h3;
            end else if (mask_dly_reg == 2'h1) begin
                mask_reg <= mask_stage_reg;
            end
        end
    end

    // blocks acceptance until the instruction after the control one ends
    always_ff @(posedge clk_sys or posedge sys_rst) begin
        if (sys_rst) begin
            blk_reg <= 2'h0;
        end else if (wr_mask) begin
            blk_reg <= irts_pkg::BLOCK_INSNS;
        end else if (cpu_insn_end && blk_reg != 2'h0) begin
            blk_reg <= blk_reg - 2'h1;
        end
    end

    // =====================================
    // exception sequence timing
    logic accept;
    logic [5:0] stk_st, prg_st;
    // a cpu-path source that is also a transfer source only gets here after act clears
    assign accept = state_reg == irts_pkg::SEQ_IDLE && cpu_any && blk_reg == 2'h0;
    assign stk_st = irts_pkg::acc_states(stk_cfg_reg);
    assign prg_st = irts_pkg::acc_states(prg_cfg_reg);

    always_ff @(posedge clk_sys or posedge sys_rst) begin
        if (sys_rst) begin
            state_reg <= irts_pkg::SEQ_IDLE;
            cnt_reg <= 6'h00;
            ext_reg <= 1'b0;
            end_seen_reg <= 1'b0;
        end else begin
            case (state_reg)
                irts_pkg::SEQ_IDLE: begin
                    if (accept) begin
                        state_reg <= irts_pkg::SEQ_PRIO;
                        ext_reg <= irts_pkg::EXT_SRC_MASK[cpu_idx];
                        cnt_reg <= irts_pkg::EXT_SRC_MASK[cpu_idx] ? 6'(irts_pkg::PRIO_EXT_ST - 4'h1)
                                                                  : 6'(irts_pkg::PRIO_INT_ST - 4'h1);
                        end_seen_reg <= 1'b0;
                    end
                end
                irts_pkg::SEQ_PRIO: begin
                    end_seen_reg <= end_seen_reg | cpu_insn_end;
                    if (cnt_reg == 6'h00) begin
                        state_reg <= irts_pkg::SEQ_WAIT;
                    end else begin
                        cnt_reg <= cnt_reg - 6'h01;
                    end
                end
                irts_pkg::SEQ_WAIT: begin
                    if (cpu_insn_end || end_seen_reg) begin
                        state_reg <= irts_pkg::SEQ_INT1;
                    end
                end
                irts_pkg::SEQ_INT1: begin
                    state_reg <= irts_pkg::SEQ_SAVE;
                    cnt_reg <= 6'({stk_st[4:0], 1'b0} - 6'h01);
                end
                irts_pkg::SEQ_SAVE: begin
                    if (cnt_reg == 6'h00) begin
                        state_reg <= irts_pkg::SEQ_VEC;
                        cnt_reg <= 6'({prg_st[4:0], 1'b0} - 6'h01);
                    end else begin
                        cnt_reg <= cnt_reg - 6'h01;
                    end
                end
                irts_pkg::SEQ_VEC: begin
                    if (cnt_reg == 6'h00) begin
                        state_reg <= irts_pkg::SEQ_INT2;
                    end else begin
                        cnt_reg <= cnt_reg - 6'h01;
                    end
                end
                irts_pkg::SEQ_INT2: begin
                    state_reg <= irts_pkg::SEQ_FETCH;
                    cnt_reg <= 6'({prg_st[4:0], 1'b0} - 6'h01);
                end
                default: begin
                    if (cnt_reg == 6'h00) begin
                        state_reg <= irts_pkg::SEQ_IDLE;
                    end else begin
                        cnt_reg <= cnt_reg - 6'h01;
                    end
                end
            endcase
        end
    end

    logic seq_end;
    assign seq_end = state_reg == irts_pkg::SEQ_FETCH && cnt_reg == 6'h00;

    // response count in system clock states, restarted per request
    always_ff @(posedge clk_sys or posedge sys_rst) begin
        if (sys_rst) begin
            resp_reg <= 8'h00;
            resp_last_reg <= 8'h00;
            handler_start_reg <= 1'b0;
            cpu_irq_reg <= '0;
        end else begin
            handler_start_reg <= seq_end;
            if (accept) begin
                resp_reg <= 8'h01;
                cpu_irq_reg <= '{req: 1'b1, src: cpu_idx};
            end else if (state_reg != irts_pkg::SEQ_IDLE) begin
                resp_reg <= resp_reg + 8'h01;
            end
            if (seq_end) begin
                resp_last_reg <= resp_reg;
                cpu_irq_reg.req <= 1'b0;
            end
        end
    end

    // =====================================
    // checks
    a_prio_ext_len: assert property (@(posedge clk_sys) disable iff (sys_rst)
        (state_reg == irts_pkg::SEQ_PRIO && $past(state_reg) == irts_pkg::SEQ_IDLE && ext_reg)
        |-> (state_reg == irts_pkg::SEQ_PRIO)[*3] ##1 state_reg == irts_pkg::SEQ_WAIT)
        else $error("external priority phase not 3 states");
    a_prio_int_len: assert property (@(posedge clk_sys) disable iff (sys_rst)
        (state_reg == irts_pkg::SEQ_PRIO && $past(state_reg) == irts_pkg::SEQ_IDLE && !ext_reg)
        |-> (state_reg == irts_pkg::SEQ_PRIO)[*2] ##1 state_reg == irts_pkg::SEQ_WAIT)
        else $error("internal priority phase not 2 states");
    a_internal_step: assert property (@(posedge clk_sys) disable iff (sys_rst)
        state_reg == irts_pkg::SEQ_INT1 |-> $past(state_reg) == irts_pkg::SEQ_WAIT
        ##1 state_reg == irts_pkg::SEQ_SAVE)
        else $error("internal step misplaced");
    a_resp_min: assert property (@(posedge clk_sys) disable iff (sys_rst)
        handler_start_reg |-> resp_last_reg >= irts_pkg::RESP_MIN_ST && state_reg == irts_pkg::SEQ_IDLE)
        else $error("response shorter than minimum");
    a_xfer_flag_clear: assert property (@(posedge clk_sys) disable iff (sys_rst)
        (xs_done && !xs_sel && !xfer_last && !src_event[xs]) |=> !flag_reg[$past(xs)])
        else $error("transfer did not clear source flag");
    a_act_en_clear: assert property (@(posedge clk_sys) disable iff (sys_rst)
        (xs_done && (xs_sel || xfer_last) && !wr_act) |=> !act_reg[$past(xs)] && !xfer_req_reg.req)
        else $error("activation enable not cleared");
    a_mask_delay: assert property (@(posedge clk_sys) disable iff (sys_rst)
        (cpu_insn_end && mask_wait_reg && !wr_mask) ##1 !wr_mask ##1 !seq_masks
        |=> mask_reg == $past(mask_stage_reg, 3))
        else $error("mask not applied two states after instruction");
    a_block_accept: assert property (@(posedge clk_sys) disable iff (sys_rst)
        (blk_reg != 2'h0 && state_reg == irts_pkg::SEQ_IDLE) |=> state_reg == irts_pkg::SEQ_IDLE)
        else $error("interrupt accepted while blocked");
    a_cpu_steer: assert property (@(posedge clk_sys) disable iff (sys_rst)
        accept |-> !act_reg[cpu_idx] && lvl_ok[cpu_idx])
        else $error("cpu accepted a transfer-only or masked source");
    a_xfer_hold: assert property (@(posedge clk_sys) disable iff (sys_rst)
        (xfer_req_reg.req && !xfer_done) |=> xfer_req_reg.req && $stable(xfer_req_reg.src))
        else $error("transfer request dropped early");

    c_handler: cover property (@(posedge clk_sys) disable iff (sys_rst) handler_start_reg);
    c_both_paths: cover property (@(posedge clk_sys) disable iff (sys_rst) xs_done && xs_sel);
    c_mask_apply: cover property (@(posedge clk_sys) disable iff (sys_rst) mask_dly_reg == 2'h1);
endmodule : irts_top
`default_nettype wire
